// ### hw/ppm_pkg.sv
// constants, types and register layout of the parallel port pin multiplexer
package ppm_pkg;

  // ***************************************************************
  // register map and field layout
  // ***************************************************************
  localparam logic [31:0] ROUTE_SEL_ADDR = 32'h0000_1c00;
  localparam int RESERVED_BIT = 15;
  localparam int ROUTE_MSB    = 14;
  localparam int ROUTE_LSB    = 12;
  localparam int AUX_MSB      = 11;
  localparam int LANE0_MSB    = 7;
  localparam int LANE1_LSB    = 8;
  localparam int REG_W        = 16;
  localparam int BUS_W        = 32;
  localparam logic        RESERVED_VAL = 1'b0;
  localparam logic [2:0]  ROUTE_RESET  = 3'h0;
  localparam logic [11:0] AUX_RESET    = 12'h000;
  localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

  // ***************************************************************
  // route codes of the mode field
  // ***************************************************************
  localparam logic [2:0] MODE_LCD16          = 3'h0;
  localparam logic [2:0] MODE_SPI_GPIO_UART  = 3'h1;
  localparam logic [2:0] MODE_LCD8_GPIO      = 3'h2;
  localparam logic [2:0] MODE_LCD8_SPI_ASP3  = 3'h3;
  localparam logic [2:0] MODE_LCD8_ASP2_UART = 3'h4;
  localparam logic [2:0] MODE_LCD8_SPI_UART  = 3'h5;
  localparam logic [2:0] MODE_SPI_ASP_GPIO   = 3'h6;

  // ***************************************************************
  // peripheral widths and their slots in the flat source vector
  // ***************************************************************
  localparam int NUM_PINS   = 21;
  localparam int LCD_W      = 21;
  localparam int LCD_DATA8  = 8;
  localparam int LCD_CTRL_W = 5;
  localparam int SPI_W      = 7;
  localparam int SPI_NARROW = 4;
  localparam int UART_W     = 4;
  localparam int ASP_W      = 4;
  localparam int GPIO_W     = 8;
  localparam int GPIO_SIX   = 6;
  localparam int LCD_BASE   = 0;
  localparam int SPI_BASE   = 21;
  localparam int UART_BASE  = 28;
  localparam int ASP2_BASE  = 32;
  localparam int ASP3_BASE  = 36;
  localparam int GPIO_BASE  = 40;
  localparam int NUM_SRC    = 48;

  // ***************************************************************
  // first pin of each group inside the route layouts
  // ***************************************************************
  localparam int LCD_CTRL_PIN = 16;
  localparam int BLK_A_PIN    = 8;
  localparam int BLK_B_PIN    = 12;
  localparam int M1_GPIO_PIN  = 7;
  localparam int M1_UART_PIN  = 13;
  localparam int M1_ASP2_PIN  = 17;
  localparam int M6_ASP2_PIN  = 7;
  localparam int M6_ASP3_PIN  = 11;
  localparam int M6_GPIO_PIN  = 15;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef logic [2:0] ppm_mode_t;
  typedef logic [5:0] ppm_src_idx_t;
  typedef logic [NUM_PINS-1:0][5:0] ppm_idx_vec_t;

  typedef struct packed {
    logic [11:0] aux;
    ppm_mode_t   route;
    logic        ack;
    logic [31:0] rdata;
  } ppm_state_t;

endpackage

// ### hw/ppm_route_table.sv
// route table: source slot chosen for each port pin in each mode
`timescale 1ns/1ps
module ppm_route_table (
  // route select
  input  wire ppm_pkg::ppm_mode_t            mode_i,
  // per-pin selection
  output logic [ppm_pkg::NUM_PINS-1:0]       pin_valid_o,
  output ppm_pkg::ppm_idx_vec_t              pin_idx_o
);
  import ppm_pkg::*;

  // one group of n consecutive pins from lo fed by sources from base
  function automatic logic [6:0] ppm_pick(input int p, input int lo,
                                          input int n, input int base);
    logic [6:0] r;
    r = 7'h00;
    if (p >= lo && p < lo + n) begin
      r = {1'b1, 6'(base + p - lo)};
    end
    return r;
  endfunction

  // eight-bit pixel layout: data low, control signals at the top pins
  function automatic logic [6:0] ppm_lcd8(input int p);
    logic [6:0] r;
    r = ppm_pick(p, 0, LCD_DATA8, LCD_BASE)
      | ppm_pick(p, LCD_CTRL_PIN, LCD_CTRL_W, LCD_BASE + LCD_CTRL_PIN);
    return r;
  endfunction

  // ***************************************************************
  // per-pin decode
  // ***************************************************************
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic [6:0] entry;

    // pick the source for this pin from the mode
    always_comb begin
      case (mode_i)
        MODE_LCD16: begin
          entry = ppm_pick(p, 0, LCD_W, LCD_BASE);
        end
        MODE_SPI_GPIO_UART: begin
          entry = ppm_pick(p, 0, SPI_W, SPI_BASE)
                | ppm_pick(p, M1_GPIO_PIN, GPIO_SIX, GPIO_BASE)
                | ppm_pick(p, M1_UART_PIN, UART_W, UART_BASE)
                | ppm_pick(p, M1_ASP2_PIN, ASP_W, ASP2_BASE);
        end
        MODE_LCD8_GPIO: begin
          entry = ppm_lcd8(p)
                | ppm_pick(p, BLK_A_PIN, GPIO_W, GPIO_BASE);
        end
        MODE_LCD8_SPI_ASP3: begin
          entry = ppm_lcd8(p)
                | ppm_pick(p, BLK_A_PIN, SPI_NARROW, SPI_BASE)
                | ppm_pick(p, BLK_B_PIN, ASP_W, ASP3_BASE);
        end
        MODE_LCD8_ASP2_UART: begin
          entry = ppm_lcd8(p)
                | ppm_pick(p, BLK_A_PIN, ASP_W, ASP2_BASE)
                | ppm_pick(p, BLK_B_PIN, UART_W, UART_BASE);
        end
        MODE_LCD8_SPI_UART: begin
          entry = ppm_lcd8(p)
                | ppm_pick(p, BLK_A_PIN, SPI_NARROW, SPI_BASE)
                | ppm_pick(p, BLK_B_PIN, UART_W, UART_BASE);
        end
        MODE_SPI_ASP_GPIO: begin
          entry = ppm_pick(p, 0, SPI_W, SPI_BASE)
                | ppm_pick(p, M6_ASP2_PIN, ASP_W, ASP2_BASE)
                | ppm_pick(p, M6_ASP3_PIN, ASP_W, ASP3_BASE)
                | ppm_pick(p, M6_GPIO_PIN, GPIO_SIX, GPIO_BASE);
        end
        default: begin
          entry = 7'h00; // unlisted code leaves every pin undriven
        end
      endcase
    end

    assign pin_valid_o[p] = entry[6];
    assign pin_idx_o[p]   = entry[5:0];
  end

endmodule

// ### hw/ppm_pin_mux.sv
// parallel port pin multiplexer with its wishbone route select register
`timescale 1ns/1ps
module ppm_pin_mux (
  // clock and reset
  input  wire  logic                         clk_i,
  input  wire  logic                         rst_i,
  // wishbone slave
  input  wire  logic                         wb_cyc_i,
  input  wire  logic                         wb_stb_i,
  input  wire  logic                         wb_we_i,
  input  wire  logic [31:0]                  wb_adr_i,
  input  wire  logic [3:0]                   wb_sel_i,
  input  wire  logic [31:0]                  wb_dat_i,
  output logic       [31:0]                  wb_dat_o,
  output logic                               wb_ack_o,
  // current route code
  output ppm_pkg::ppm_mode_t                 route_mode_o,
  // lcd bridge
  input  wire  logic [ppm_pkg::LCD_W-1:0]    lcd_out_i,
  input  wire  logic [ppm_pkg::LCD_W-1:0]    lcd_oe_i,
  output logic       [ppm_pkg::LCD_W-1:0]    lcd_in_o,
  // spi
  input  wire  logic [ppm_pkg::SPI_W-1:0]    spi_out_i,
  input  wire  logic [ppm_pkg::SPI_W-1:0]    spi_oe_i,
  output logic       [ppm_pkg::SPI_W-1:0]    spi_in_o,
  // uart
  input  wire  logic [ppm_pkg::UART_W-1:0]   uart_out_i,
  input  wire  logic [ppm_pkg::UART_W-1:0]   uart_oe_i,
  output logic       [ppm_pkg::UART_W-1:0]   uart_in_o,
  // audio serial port two
  input  wire  logic [ppm_pkg::ASP_W-1:0]    asp2_out_i,
  input  wire  logic [ppm_pkg::ASP_W-1:0]    asp2_oe_i,
  output logic       [ppm_pkg::ASP_W-1:0]    asp2_in_o,
  // audio serial port three
  input  wire  logic [ppm_pkg::ASP_W-1:0]    asp3_out_i,
  input  wire  logic [ppm_pkg::ASP_W-1:0]    asp3_oe_i,
  output logic       [ppm_pkg::ASP_W-1:0]    asp3_in_o,
  // general purpose pins
  input  wire  logic [ppm_pkg::GPIO_W-1:0]   gpio_out_i,
  input  wire  logic [ppm_pkg::GPIO_W-1:0]   gpio_oe_i,
  output logic       [ppm_pkg::GPIO_W-1:0]   gpio_in_o,
  // parallel port pins
  input  wire  logic [ppm_pkg::NUM_PINS-1:0] pin_in_i,
  output logic       [ppm_pkg::NUM_PINS-1:0] pin_out_o,
  output logic       [ppm_pkg::NUM_PINS-1:0] pin_oe_o
);
  import ppm_pkg::*;

  // ***************************************************************
  // declarations
  // ***************************************************************
  ppm_state_t                 state_q;
  ppm_state_t                 state_d;
  logic                       req;
  logic                       hit;
  logic                       commit;
  logic [REG_W-1:0]           reg_view;
  logic [REG_W-1:0]           wr_merged;
  logic [NUM_SRC-1:0]         src_out;
  logic [NUM_SRC-1:0]         src_oe;
  logic [NUM_SRC-1:0]         src_in;
  logic [NUM_PINS-1:0]        pin_valid;
  ppm_idx_vec_t               pin_idx;

  // ***************************************************************
  // bus decode helpers
  // ***************************************************************

  // true when the word address is the route select register
  function automatic logic ppm_addr_hit(input logic [31:0] adr);
    return adr == ROUTE_SEL_ADDR;
  endfunction

  // replace the bytes of old picked by the lane enables
  function automatic logic [REG_W-1:0] ppm_lane_merge(
      input logic [REG_W-1:0] old_v,
      input logic [REG_W-1:0] new_v,
      input logic [1:0]       sel);
    logic [REG_W-1:0] r;
    r = old_v;
    if (sel[0]) begin
      r[LANE0_MSB:0] = new_v[LANE0_MSB:0];
    end
    if (sel[1]) begin
      r[REG_W-1:LANE1_LSB] = new_v[REG_W-1:LANE1_LSB];
    end
    return r;
  endfunction

  // ***************************************************************
  // bus request qualification
  // ***************************************************************

  // a live request and whether it targets the register
  assign req = wb_cyc_i & wb_stb_i;
  assign hit = ppm_addr_hit(wb_adr_i);

  // a write lands on the edge at which ack is seen high
  assign commit = req & wb_we_i & state_q.ack & hit;

  // register as software sees it, top bit fixed
  assign reg_view = {RESERVED_VAL, state_q.route, state_q.aux};

  // write data merged by byte lanes
  assign wr_merged = ppm_lane_merge(reg_view, wb_dat_i[REG_W-1:0],
                                    wb_sel_i[1:0]);

  // ***************************************************************
  // next state
  // ***************************************************************

  // acknowledge, read capture and register update
  always_comb begin
    state_d = state_q;
    // one ack per request, dropped in the cycle after it was given
    state_d.ack = req & ~state_q.ack;
    // read data is captured with the ack, zero for unmapped words
    if (req & ~state_q.ack) begin
      if (hit) begin
        state_d.rdata = {{(BUS_W - REG_W){1'b0}}, reg_view};
      end else begin
        state_d.rdata = RDATA_RESET;
      end
    end
    // the reserved bit is not stored, so its write is dropped
    if (commit) begin
      state_d.aux   = wr_merged[AUX_MSB:0];
      state_d.route = wr_merged[ROUTE_MSB:ROUTE_LSB];
    end
    if (rst_i) begin
      state_d.aux   = AUX_RESET;
      state_d.route = ROUTE_RESET;
      state_d.ack   = 1'b0;
      state_d.rdata = RDATA_RESET;
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************

  // whole state in one flop bank, reset folded into next state
  always_ff @(posedge clk_i) begin
    state_q <= state_d; // new route reaches the pins after this edge
  end

  // ***************************************************************
  // bus outputs
  // ***************************************************************

  // read data and ack straight from flops
  assign wb_dat_o     = state_q.rdata;
  assign wb_ack_o     = state_q.ack;
  assign route_mode_o = state_q.route;

  // ***************************************************************
  // route table
  // ***************************************************************

  // per-pin source slot for the stored route code
  ppm_route_table u_route_table (
    .mode_i      (state_q.route),
    .pin_valid_o (pin_valid),
    .pin_idx_o   (pin_idx)
  );

  // ***************************************************************
  // flat source vectors
  // ***************************************************************

  // peripheral drive values gathered into one vector
  assign src_out = {gpio_out_i, asp3_out_i, asp2_out_i,
                    uart_out_i, spi_out_i, lcd_out_i};

  // peripheral enables gathered the same way
  assign src_oe = {gpio_oe_i, asp3_oe_i, asp2_oe_i,
                   uart_oe_i, spi_oe_i, lcd_oe_i};

  // ***************************************************************
  // pin side: outgoing values and enables
  // ***************************************************************

  // each pin follows its routed source, unrouted pins stay off
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin_out
    always_comb begin
      if (pin_valid[p]) begin
        pin_out_o[p] = src_out[pin_idx[p]];
        pin_oe_o[p]  = src_oe[pin_idx[p]];
      end else begin
        pin_out_o[p] = 1'b0; // no driver, no conflict
        pin_oe_o[p]  = 1'b0;
      end
    end
  end

  // ***************************************************************
  // peripheral side: incoming pin levels
  // ***************************************************************

  // each source slot hears the pin routed to it, else zero
  for (genvar j = 0; j < NUM_SRC; j++) begin : g_src_in
    always_comb begin
      src_in[j] = 1'b0;
      for (int p = 0; p < NUM_PINS; p++) begin
        if (pin_valid[p] && pin_idx[p] == ppm_src_idx_t'(j)) begin
          src_in[j] = src_in[j] | pin_in_i[p];
        end
      end
    end
  end

  // ***************************************************************
  // peripheral input split
  // ***************************************************************

  // slices of the flat input vector back to each peripheral
  assign lcd_in_o  = src_in[LCD_BASE  +: LCD_W];
  assign spi_in_o  = src_in[SPI_BASE  +: SPI_W];
  assign uart_in_o = src_in[UART_BASE +: UART_W];
  assign asp2_in_o = src_in[ASP2_BASE +: ASP_W];
  assign asp3_in_o = src_in[ASP3_BASE +: ASP_W];
  assign gpio_in_o = src_in[GPIO_BASE +: GPIO_W];

  // peripherals see no glitch protection while the route changes;
  // they are expected to be clock gated and reset around it

endmodule

// ### dv/ppm_pin_mux_props.sv
// checker of the route select register and the per-mode pin routing
`timescale 1ns/1ps
module ppm_pin_mux_props (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave side
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [31:0]                  wb_adr_i,
  input  wire logic [3:0]                   wb_sel_i,
  input  wire logic [31:0]                  wb_dat_i,
  input  wire logic [31:0]                  wb_dat_o,
  input  wire logic                         wb_ack_o,
  input  wire ppm_pkg::ppm_mode_t           route_mode_o,
  // peripheral drivers
  input  wire logic [ppm_pkg::LCD_W-1:0]    lcd_out_i,
  input  wire logic [ppm_pkg::LCD_W-1:0]    lcd_oe_i,
  input  wire logic [ppm_pkg::SPI_W-1:0]    spi_out_i,
  input  wire logic [ppm_pkg::UART_W-1:0]   uart_out_i,
  input  wire logic [ppm_pkg::ASP_W-1:0]    asp2_out_i,
  input  wire logic [ppm_pkg::ASP_W-1:0]    asp3_out_i,
  input  wire logic [ppm_pkg::GPIO_W-1:0]   gpio_out_i,
  // port pins
  input  wire logic [ppm_pkg::NUM_PINS-1:0] pin_out_o,
  input  wire logic [ppm_pkg::NUM_PINS-1:0] pin_oe_o
);
  import ppm_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ***************************************************************
  // register behaviour
  // ***************************************************************
  reserved_bit_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[15] == 1'b0)
    else $error("reserved bit read back as one");
  route_update_a: assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[1]
    && wb_adr_i == ROUTE_SEL_ADDR |=> route_mode_o == $past(wb_dat_i[14:12])) else $error("route code not taken");
  route_hold_a: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(route_mode_o))
    else $error("route code changed without a write");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged on the next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  // ***************************************************************
  // pin routing per mode
  // ***************************************************************
  mode_zero_a: assert property (route_mode_o == 3'h0 |-> pin_out_o == lcd_out_i && pin_oe_o == lcd_oe_i)
    else $error("mode 0 routing wrong");
  mode_one_a: assert property (route_mode_o == 3'h1 |-> pin_out_o[6:0] == spi_out_i
    && pin_out_o[16:13] == uart_out_i && pin_out_o[20:17] == asp2_out_i) else $error("mode 1 routing wrong");
  mode_two_a: assert property (route_mode_o == 3'h2 |-> pin_out_o[15:8] == gpio_out_i
    && pin_out_o[7:0] == lcd_out_i[7:0]) else $error("mode 2 routing wrong");
  mode_three_a: assert property (route_mode_o == 3'h3 |-> pin_out_o[15:12] == asp3_out_i)
    else $error("mode 3 routing wrong");
  mode_four_a: assert property (route_mode_o == 3'h4 |-> pin_out_o[11:8] == asp2_out_i)
    else $error("mode 4 routing wrong");
  mode_five_a: assert property (route_mode_o == 3'h5 |-> pin_out_o[15:12] == uart_out_i)
    else $error("mode 5 routing wrong");
  mode_six_a: assert property (route_mode_o == 3'h6 |-> pin_out_o[20:15] == gpio_out_i[5:0]
    && pin_out_o[14:11] == asp3_out_i) else $error("mode 6 routing wrong");
  mode_seven_a: assert property (route_mode_o == 3'h7 |-> pin_oe_o == '0)
    else $error("mode 7 drives a pin");

  // main scenarios reached
  cover property (route_mode_o == 3'h7);
  cover property (route_mode_o == 3'h6);
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind ppm_pin_mux ppm_pin_mux_props ppm_pin_mux_props_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .route_mode_o(route_mode_o), .lcd_out_i(lcd_out_i),
  .lcd_oe_i(lcd_oe_i), .spi_out_i(spi_out_i), .uart_out_i(uart_out_i), .asp2_out_i(asp2_out_i),
  .asp3_out_i(asp3_out_i), .gpio_out_i(gpio_out_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

// ### dv/ppm_periph_model.sv
// far-side model: peripheral drivers and the board behind the port pins
`timescale 1ns/1ps
module ppm_periph_model (
  // pattern select
  input  wire logic        pat_i,
  // port pins seen from the board
  input  wire logic [20:0] pin_out_i,
  input  wire logic [20:0] pin_oe_i,
  output logic      [20:0] pin_in_o,
  output logic      [20:0] ext_o,
  // peripheral drivers as flat slot vectors
  output logic      [47:0] src_out_o,
  output logic      [47:0] src_oe_o
);
  // two unrelated patterns so that a swapped pin cannot hide
  always_comb begin
    src_out_o = pat_i ? 48'h3c69_d2a7_84f1 : 48'ha5c3_1e96_7b28;
    src_oe_o  = 48'h96f0_5a3c_e1d7 ^ {48{pat_i}};
    ext_o     = 21'h15a3c ^ {21{pat_i}};
  end
  // board drives a pin only while the block has released it
  assign pin_in_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_o);
endmodule

// ### dv/ppm_pin_mux_tb.sv
// self-checking testbench of the parallel port pin multiplexer
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ppm_pin_mux_tb;
  import ppm_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pat;
  logic [31:0] wb_adr_i, wb_dat_i, rd;
  logic [3:0]  wb_sel_i;
  wire  [31:0] wb_dat_o;
  wire         wb_ack_o;
  wire  [2:0]  route_mode_o;
  wire  [47:0] src_out, src_oe, src_in;
  wire  [20:0] pin_in, pin_out, pin_oe, ext;
  int          n_errors, n_checks, cycles;

  ppm_pin_mux ppm_pin_mux_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .route_mode_o(route_mode_o),
    .lcd_out_i(src_out[20:0]), .lcd_oe_i(src_oe[20:0]), .lcd_in_o(src_in[20:0]),
    .spi_out_i(src_out[27:21]), .spi_oe_i(src_oe[27:21]), .spi_in_o(src_in[27:21]),
    .uart_out_i(src_out[31:28]), .uart_oe_i(src_oe[31:28]), .uart_in_o(src_in[31:28]),
    .asp2_out_i(src_out[35:32]), .asp2_oe_i(src_oe[35:32]), .asp2_in_o(src_in[35:32]),
    .asp3_out_i(src_out[39:36]), .asp3_oe_i(src_oe[39:36]), .asp3_in_o(src_in[39:36]),
    .gpio_out_i(src_out[47:40]), .gpio_oe_i(src_oe[47:40]), .gpio_in_o(src_in[47:40]),
    .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe));
  ppm_periph_model ppm_periph_model_inst (.pat_i(pat), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
    .pin_in_o(pin_in), .ext_o(ext), .src_out_o(src_out), .src_oe_o(src_oe));

  // ***************************************************************
  // clock, timeout and verdict
  // ***************************************************************
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ***************************************************************
  // wishbone classic cycles
  // ***************************************************************
  task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [15:0] dat, input logic [3:0] sel);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    wb_sel_i <= sel;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic wb_write(input logic [31:0] adr, input logic [15:0] dat, input logic [3:0] sel);
    wb_xfer(1'b1, adr, dat, sel);
  endtask
  task automatic wb_read(input logic [31:0] adr);
    wb_xfer(1'b0, adr, 16'h0000, 4'h3);
  endtask

  // ***************************************************************
  // expected routing: source slot of each pin, -1 when unrouted
  // ***************************************************************
  function automatic int src_idx(input int m, input int p);
    if (m == 0) return p;
    if (m == 1) return p < 7 ? 21 + p : p < 13 ? 33 + p : p < 17 ? 15 + p : 15 + p;
    if (m == 6) return p < 7 ? 21 + p : p < 11 ? 25 + p : p < 15 ? 25 + p : 25 + p;
    if (m == 7) return -1;
    if (p < 8 || p > 15) return p;
    if (m == 2) return 32 + p;
    if (m == 3) return p < 12 ? 13 + p : 24 + p;
    if (m == 4) return p < 12 ? 24 + p : 16 + p;
    return p < 12 ? 13 + p : 16 + p;
  endfunction
  task automatic check_routes(input logic [2:0] m);
    logic [20:0] eo, ee;
    logic [47:0] ei;
    int          idx;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      pat <= k[0]; // each route is checked with both driver patterns
      #1;
      eo = '0;
      ee = '0;
      ei = '0;
      for (int p = 0; p < 21; p++) begin
        idx = src_idx(int'(m), p);
        if (idx >= 0) begin
          eo[p] = src_out[idx];
          ee[p] = src_oe[idx];
          ei[idx] = ee[p] ? eo[p] : ext[p];
        end
      end
      `CHK(pin_out, eo)
      `CHK(pin_oe, ee)
      `CHK(src_in, ei)
    end
  endtask

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, pat} = 5'h10;
    wb_adr_i = '0;
    wb_dat_i = '0;
    wb_sel_i = '0;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_read(ROUTE_SEL_ADDR);
    `CHK(rd, 32'h0000_0000)
    check_routes(3'h0);
    $display("test reset_state done");
    // every route code, reserved bit set on each write
    for (int m = 0; m < 8; m++) begin
      wb_write(ROUTE_SEL_ADDR, {1'b1, m[2:0], 12'ha5c}, 4'h3);
      #1;
      `CHK(route_mode_o, m[2:0])
      check_routes(m[2:0]);
      wb_read(ROUTE_SEL_ADDR);
      `CHK(rd, {16'h0000, 1'b0, m[2:0], 12'ha5c})
    end
    $display("test all_modes done");
    // byte lanes: low lane keeps the route, high lane drops bit 15
    wb_write(ROUTE_SEL_ADDR, 16'h0000, 4'h1);
    wb_read(ROUTE_SEL_ADDR);
    `CHK(rd, 32'h0000_7a00)
    wb_write(ROUTE_SEL_ADDR, 16'h8123, 4'h2);
    wb_read(ROUTE_SEL_ADDR);
    `CHK(rd, 32'h0000_0100)
    $display("test byte_lanes done");
    // unmapped address neither stores nor reads back
    wb_write(ROUTE_SEL_ADDR + 32'h4, 16'h3000, 4'h3);
    wb_read(ROUTE_SEL_ADDR + 32'h4);
    `CHK(rd, 32'h0000_0000)
    `CHK(route_mode_o, 3'h0)
    $display("test unmapped done");
    // reset in mid-run returns to the 16-bit panel layout
    wb_write(ROUTE_SEL_ADDR, 16'h5000, 4'h3);
    #1;
    `CHK(route_mode_o, 3'h5)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    check_routes(3'h0);
    wb_read(ROUTE_SEL_ADDR);
    `CHK(rd, 32'h0000_0000)
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule
